// ===== logic/dag_gpio_port.sv
`timescale 1ns/1ns
`default_nettype none
module dag_gpio_port (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // host pin port control
    input wire logic port_en_req,
    input wire logic port_dis_req,
    input wire logic [dag_pkg::NUM_PINS-1:0] dir_in,
    input wire logic [dag_pkg::NUM_PINS-1:0] out_in,
    input wire logic cfg_wr,
    input wire logic tool_reset_req,
    input wire logic tool_ctrl,
    // other functions
    input wire logic scan_en,
    input wire logic [dag_pkg::NUM_SERIAL_PORTS-1:0] serial_en,
    input wire logic [dag_pkg::FMT_W-1:0] fmt_in,
    input wire logic [2:0] class_in,
    input wire logic two_wire_in,
    input wire logic fmt_wr,
    // pins
    input wire logic [dag_pkg::NUM_PINS-1:0] pin_i,
    output logic [dag_pkg::NUM_PINS-1:0] pin_o,
    output logic [dag_pkg::NUM_PINS-1:0] pin_oe,
    // status
    output logic pin_io_port_on,
    output logic [dag_pkg::NUM_PINS-1:0] pin_in_q,
    output logic [dag_pkg::FMT_W-1:0] scan_fmt_q,
    output logic [2:0] target_class_q,
    output logic two_wire_q,
    output logic serial_conflict,
    output logic fmt_err_q
);
    import dag_pkg::*;

    typedef enum logic {
        PORT_OFF,
        PORT_ON
    } dag_port_state_t;

    dag_port_state_t port_state_q;
    logic busy;
    logic port_live;
    logic [NUM_PINS-1:0] dir_q;
    logic [NUM_PINS-1:0] out_q;
    logic [NUM_PINS-1:0] sync1_q;
    logic rst_drive_q;
    logic [NUM_PINS-1:0] pin_oe_d;
    logic [NUM_PINS-1:0] pin_o_d;
    logic serial_conflict_q;
    logic fmt_accept;

    // scan format code inside the joint, mixed and optimised range
    function automatic logic fmt_ok(input logic [FMT_W-1:0] f);
        fmt_ok = (f <= FMT_OSCAN7);
    endfunction : fmt_ok

    // target class zero to four
    function automatic logic class_ok(input logic [2:0] c);
        class_ok = (c <= CLASS_MAX);
    endfunction : class_ok

    // more than one bit set
    function automatic logic multi_hot(input logic [NUM_SERIAL_PORTS-1:0] v);
        multi_hot = (v & (v - NUM_SERIAL_PORTS'(1))) != '0;
    endfunction : multi_hot

    // driver enable of one pin
    function automatic logic pin_drive(input logic live, input logic dis, input logic dir);
        pin_drive = live && !dis && dir;
    endfunction : pin_drive

    // scan or serial function owns the shared lines
    assign busy = scan_en || (serial_en != '0);
    assign port_live = (port_state_q == PORT_ON) && !busy;
    assign fmt_accept = fmt_ok(fmt_in) && class_ok(class_in);

    // pin port state
    always_ff @(posedge mclk) begin
        if (srst) begin
            port_state_q <= PORT_OFF;
        end else begin
            unique case (port_state_q)
                PORT_OFF: begin
                    // disable wins; enable ignored while busy
                    if (port_en_req && !port_dis_req && !busy) begin
                        port_state_q <= PORT_ON;
                    end
                end
                PORT_ON: begin
                    if (port_dis_req || busy) begin
                        port_state_q <= PORT_OFF;
                    end
                end
            endcase
        end
    end

    // direction, one means output
    always_ff @(posedge mclk) begin
        if (srst) begin
            dir_q <= DIR_RST;
        end else if (cfg_wr) begin
            dir_q <= dir_in;
        end
    end

    // output levels for driven pins
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_q <= OUT_RST;
        end else if (cfg_wr) begin
            out_q <= out_in;
        end
    end

    // tool-driven target reset request
    always_ff @(posedge mclk) begin
        if (srst) begin
            rst_drive_q <= 1'b0;
        end else begin
            rst_drive_q <= tool_ctrl && tool_reset_req;
        end
    end

    // two-stage input synchroniser
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_q <= '0;
        end else begin
            sync1_q <= pin_i;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_in_q <= '0;
        end else begin
            pin_in_q <= sync1_q;
        end
    end

    // next driver state per pin
    always_comb begin
        pin_oe_d = '0;
        pin_o_d = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            pin_oe_d[i] = pin_drive(port_live, port_dis_req, dir_q[i]);
            pin_o_d[i] = out_q[i];
        end
        // reserved pin: active-low target reset, released unless requested
        if (tool_ctrl) begin
            pin_oe_d[RESET_PIN] = pin_drive(port_live, port_dis_req, rst_drive_q);
            pin_o_d[RESET_PIN] = 1'b0;
        end
    end

    // registered drivers, all released in reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_oe <= '0;
        end else begin
            pin_oe <= pin_oe_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_o <= '0;
        end else begin
            pin_o <= pin_o_d;
        end
    end

    // scan setup, written only when legal
    always_ff @(posedge mclk) begin
        if (srst) begin
            scan_fmt_q <= FMT_RST;
        end else if (fmt_wr && fmt_accept) begin
            scan_fmt_q <= fmt_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            target_class_q <= CLASS_RST;
        end else if (fmt_wr && fmt_accept) begin
            target_class_q <= class_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            two_wire_q <= 1'b0;
        end else if (fmt_wr && fmt_accept) begin
            two_wire_q <= two_wire_in;
        end
    end

    // refused setup leaves the previous one in place
    always_ff @(posedge mclk) begin
        if (srst) begin
            fmt_err_q <= 1'b0;
        end else if (fmt_wr) begin
            fmt_err_q <= !fmt_accept;
        end
    end

    // flags more than one serial port enabled
    always_ff @(posedge mclk) begin
        if (srst) begin
            serial_conflict_q <= 1'b0;
        end else begin
            serial_conflict_q <= multi_hot(serial_en);
        end
    end

    // status outputs
    assign serial_conflict = serial_conflict_q;
    assign pin_io_port_on = (port_state_q == PORT_ON);
endmodule : dag_gpio_port
`default_nettype wire

// ===== logic/dag_pkg.sv
// Functional notes
// - three pins, independent input and driver
// - all drivers off after reset
// - drive only when port enabled and output, or reset pin when port enabled and tool requests reset
// - port disable returns all pins high-z
// - port usable only with scan, serial idle
// - third pin reserved as target reset
// - tools may assert target reset on demand
// - accepts compact scan formats, joint, mixed, optimised
// - four-wire and two-wire, classes zero to four
// - flags more than one serial port enabled at once
package dag_pkg;
    localparam int NUM_PINS = 3;
    localparam int RESET_PIN = 2;
    localparam logic [NUM_PINS-1:0] DIR_RST = 3'h0;
    localparam logic [NUM_PINS-1:0] OUT_RST = 3'h0;
    localparam int NUM_SERIAL_PORTS = 8;
    localparam int FMT_W = 4;
    // scan format codes
    localparam logic [FMT_W-1:0] FMT_JSCAN0 = 4'h0;
    localparam logic [FMT_W-1:0] FMT_JSCAN3 = 4'h3;
    localparam logic [FMT_W-1:0] FMT_MSCAN = 4'h4;
    localparam logic [FMT_W-1:0] FMT_OSCAN0 = 4'h5;
    localparam logic [FMT_W-1:0] FMT_OSCAN7 = 4'hc;
    localparam logic [FMT_W-1:0] FMT_RST = 4'h0;
    localparam logic [2:0] CLASS_MAX = 3'h4;
    localparam logic [2:0] CLASS_RST = 3'h0;
endpackage : dag_pkg

// ===== bench/dag_board.sv
`timescale 1ns/1ns
`default_nettype none
module dag_board (
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    output logic [2:0] pin_i
);
    // weak pull-ups hold released pins high; pin 2 is target_cpu_reset_n
    assign pin_i = (pin_o & pin_oe) | ~pin_oe;
endmodule : dag_board
`default_nettype wire

// ===== bench/dag_gpio_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dag_gpio_port_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // watched controls
    input wire logic port_en_req,
    input wire logic port_dis_req,
    input wire logic scan_en,
    input wire logic [7:0] serial_en,
    input wire logic fmt_wr,
    input wire logic [3:0] fmt_in,
    input wire logic [2:0] class_in,
    // watched outputs
    input wire logic pin_io_port_on,
    input wire logic [2:0] pin_oe,
    input wire logic [3:0] scan_fmt_q,
    input wire logic fmt_err_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic busy = scan_en || (|serial_en);
    AST_DIS: assert property (port_dis_req |=> !pin_io_port_on && pin_oe == 3'h0) else $error("dis");
    AST_BUSY: assert property (busy |=> pin_oe == 3'h0) else $error("busy");
    AST_HOLD: assert property (busy && !pin_io_port_on |=> !pin_io_port_on) else $error("hold");
    AST_OE: assert property (pin_oe != 3'h0 |-> pin_io_port_on) else $error("oe");
    AST_RST: assert property ($past(srst) |-> pin_oe == 3'h0) else $error("rst");
    AST_EN: assert property (port_en_req && !port_dis_req && !busy |=> pin_io_port_on) else $error("en");
    AST_FMT: assert property (fmt_wr && fmt_in <= 4'hc && class_in <= 3'h4
        |=> scan_fmt_q == $past(fmt_in) && !fmt_err_q) else $error("fmt");
    AST_BAD: assert property (fmt_wr && fmt_in > 4'hc |=> fmt_err_q && $stable(scan_fmt_q)) else $error("bad");
endmodule : dag_gpio_port_checker
bind dag_gpio_port dag_gpio_port_checker u_chk (
    .mclk(mclk),
    .srst(srst),
    .port_en_req(port_en_req),
    .port_dis_req(port_dis_req),
    .scan_en(scan_en),
    .serial_en(serial_en),
    .fmt_wr(fmt_wr),
    .fmt_in(fmt_in),
    .class_in(class_in),
    .pin_io_port_on(pin_io_port_on),
    .pin_oe(pin_oe),
    .scan_fmt_q(scan_fmt_q),
    .fmt_err_q(fmt_err_q)
);
`default_nettype wire

// ===== bench/dag_gpio_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dag_gpio_port_tb;
    logic mclk = '0, srst = 1'h1, port_en_req = '0, port_dis_req = '0, cfg_wr = '0, fmt_wr = '0;
    logic tool_reset_req = '0, tool_ctrl = '0, scan_en = '0, two_wire_in = '0;
    logic [2:0] dir_in = '0, out_in = '0, class_in = '0, pin_i, pin_o, pin_oe, pin_in_q, target_class_q;
    logic [7:0] serial_en = '0;
    logic [3:0] fmt_in = '0, scan_fmt_q;
    logic pin_io_port_on, two_wire_q, serial_conflict, fmt_err_q;
    int bad_count = 0, n_tests = 0;
    dag_gpio_port u_dut (
        .mclk(mclk),
        .srst(srst),
        .port_en_req(port_en_req),
        .port_dis_req(port_dis_req),
        .dir_in(dir_in),
        .out_in(out_in),
        .cfg_wr(cfg_wr),
        .tool_reset_req(tool_reset_req),
        .tool_ctrl(tool_ctrl),
        .scan_en(scan_en),
        .serial_en(serial_en),
        .fmt_in(fmt_in),
        .class_in(class_in),
        .two_wire_in(two_wire_in),
        .fmt_wr(fmt_wr),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .pin_io_port_on(pin_io_port_on),
        .pin_in_q(pin_in_q),
        .scan_fmt_q(scan_fmt_q),
        .target_class_q(target_class_q),
        .two_wire_q(two_wire_q),
        .serial_conflict(serial_conflict),
        .fmt_err_q(fmt_err_q)
    );
    dag_board u_board (
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .pin_i(pin_i)
    );
    always #10 mclk = ~mclk;
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic summarize;
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        cyc(6);
        srst = '0;
        cyc(1);
        chk(pin_oe, 8'h0);
        chk(pin_io_port_on, 8'h0);
        dir_in = 3'h3;
        out_in = 3'h1;
        cfg_wr = 1'h1;
        cyc(1);
        cfg_wr = '0;
        // joint format chosen while the scan function still owns the line
        scan_en = 1'h1;
        port_en_req = 1'h1;
        fmt_in = 4'h3;
        fmt_wr = 1'h1;
        cyc(1);
        fmt_wr = '0;
        cyc(2);
        chk(pin_io_port_on, 8'h0);
        chk(scan_fmt_q, 8'h3);
        scan_en = '0;
        cyc(3);
        port_en_req = '0;
        chk({pin_oe, pin_o}, 8'h19);
        cyc(2);
        chk(pin_in_q, 8'h5);
        tool_ctrl = 1'h1;
        tool_reset_req = 1'h1;
        cyc(2);
        chk({pin_oe[2], pin_o[2]}, 8'h2);
        // reserved pin ignores its direction bit under tool control
        tool_reset_req = '0;
        dir_in = 3'h7;
        cfg_wr = 1'h1;
        cyc(1);
        cfg_wr = '0;
        cyc(1);
        chk(pin_oe[2], 8'h0);
        serial_en = 8'h3;
        cyc(1);
        chk({serial_conflict, pin_oe}, 8'h8);
        serial_en = '0;
        tool_reset_req = 1'h1;
        port_en_req = 1'h1;
        cyc(2);
        chk({pin_io_port_on, pin_oe}, 8'hf);
        port_dis_req = 1'h1;
        cyc(1);
        chk({pin_io_port_on, pin_oe}, 8'h0);
        port_dis_req = '0;
        port_en_req = '0;
        tool_reset_req = '0;
        tool_ctrl = '0;
        for (int f = 0; f < 14; f++) begin
            fmt_in = f[3:0];
            class_in = 3'h4;
            two_wire_in = f[0];
            fmt_wr = 1'h1;
            cyc(1);
            chk({fmt_err_q, scan_fmt_q}, f > 12 ? 8'h1c : 8'(f));
            chk({two_wire_q, target_class_q}, {4'h0, f > 12 ? 1'b0 : f[0], 3'h4});
        end
        fmt_in = '0;
        class_in = 3'h5;
        cyc(1);
        fmt_wr = '0;
        chk({fmt_err_q, scan_fmt_q}, 8'h1c);
        chk({two_wire_q, target_class_q}, 8'h4);
        summarize();
    end
endmodule : dag_gpio_port_tb
`default_nettype wire
